// ===== rtl/rasq_dev.sv
// Purpose: device end: task sequencing, buffers and acquisition sequences
// Assumes: BIT_TICK is one clock wide, once per recovered bit period
// Notes:   every task returns to idle when its work is done
//
// Operation
// - host ends each message with hang byte
// - hang byte is 00110011 or 11001100
// - receiver may discard the trailing byte
// - load sync with acquire bits after carrier
// - interrupt when second sync byte taken
// - host waits 12 bits before search task
// - interrupt after sync found, header decoded
// - interrupt after block received, 18 bytes
// - idle automatically after last block decoded
// - level acquire starts with one-bit clamp
// - then lossy peak detect, settles 16 bits
// - search within 28 bits: lossy until sync
// - no search: residual level after 30 bits
// - residual level mode from config field
// - host uses hold only during fades
// - search within 14 bits: wide until sync
// - no search: wide for 16 bits
// - medium 30 bits, then residual bandwidth
// - blind acquisition needs longer preamble
`timescale 1ns/1ps
module rasq_dev (
  // clock and reset
  input  wire logic                     CLK,
  input  wire logic                     RST_N,
  // link to host
  rasq_link_if.dev                      link,
  // demodulator side
  input  wire logic                     BIT_TICK,
  input  wire logic                     SYNC_FOUND,
  input  wire logic                     HDR_MATCH,
  input  wire logic                     CRC_OK,
  input  wire logic [7:0]               RX_BYTE,
  input  wire logic                     RX_BYTE_VLD,
  output      logic [7:0]               TX_BYTE,
  output      logic                     TX_BYTE_VLD,
  output      logic [15:0]              SYNC_WORD,
  // acquisition controls
  output      rasq_pkg::rasq_level_type LEVEL_MODE,
  output      logic                     LEVEL_SETTLED,
  output      logic [1:0]               CLOCK_PHASE,
  output      logic [1:0]               LOOP_BW
);
  import rasq_pkg::*;

  typedef enum logic [1:0] {
    DS_IDLE,
    DS_TAKE,
    DS_HUNT,
    DS_COLLECT
  } rasq_dst_type;

  typedef enum logic [1:0] {
    LP_OFF,
    LP_CLAMP,
    LP_LOSSY,
    LP_RESID
  } rasq_lph_type;

  typedef struct packed {
    rasq_dst_type   st;
    rasq_task_type  task_id;
    logic [4:0]     need;
    logic [2:0]     bitc;
    logic [17:0][7:0] wbuf;
    logic [4:0]     wcnt;
    logic [4:0]     tptr;
    logic [17:0][7:0] rbuf;
    logic [4:0]     rcnt;
    logic [4:0]     rptr;
    logic [15:0]    sync;
    logic [7:0]     tx_byte;
    logic           tx_vld;
    logic           irq;
    logic           match;
    logic           err;
    rasq_lph_type   lph;
    logic [5:0]     lcnt;
    logic           lsrch;
    logic [1:0]     cph;
    logic [5:0]     ccnt;
    logic           csrch;
  } rasq_dev_state_type;

  rasq_dev_state_type s_r;
  rasq_dev_state_type s_nxt;
  logic               is_search;
  logic               sync_hit;

  assign is_search = link.task_wr &&
                     (link.task_code == TK_SEARCH_HEAD || link.task_code == TK_SEARCH_SHORT);
  assign sync_hit  = SYNC_FOUND && s_r.st == DS_HUNT;

  ////////////////////////////////////////////////////////////////////////////
  always_comb
  begin
    s_nxt        = s_r;
    s_nxt.tx_vld = 1'b0;
    if (link.stat_rd)
    begin
      s_nxt.irq = 1'b0;
    end
    if (link.wr_strobe && s_r.wcnt < BUF_DEPTH_C)
    begin
      s_nxt.wbuf[s_r.wcnt] = link.wr_data;
      s_nxt.wcnt           = s_r.wcnt + 5'h01;
    end
    if (link.rd_strobe && s_r.rptr < s_r.rcnt)
    begin
      s_nxt.rptr = s_r.rptr + 5'h01;
    end
    if (BIT_TICK)
    begin
      s_nxt.bitc = s_r.bitc + 3'h1;
    end

    // task sequencing
    case (s_r.st)
      DS_IDLE:
      begin
      end
      DS_TAKE:
      begin
        if (s_r.tptr < s_r.wcnt &&
            (s_r.task_id == TK_LOAD_SYNC || (BIT_TICK && s_r.bitc == BYTE_LAST_BIT)))
        begin
          if (s_r.task_id == TK_LOAD_SYNC)
          begin
            s_nxt.sync = {s_r.sync[7:0], s_r.wbuf[s_r.tptr]};
          end
          else
          begin
            s_nxt.tx_byte = s_r.wbuf[s_r.tptr];
            s_nxt.tx_vld  = 1'b1;
          end
          s_nxt.tptr = s_r.tptr + 5'h01;
          s_nxt.need = s_r.need - 5'h01;
          if (s_r.need == 5'h01)
          begin
            s_nxt.irq  = 1'b1;
            s_nxt.st   = DS_IDLE;
            s_nxt.wcnt = 5'h00;
            s_nxt.tptr = 5'h00;
          end
        end
      end
      DS_HUNT:
      begin
        if (SYNC_FOUND)
        begin
          s_nxt.st   = DS_COLLECT;
          s_nxt.need = HDR_BYTES;
        end
      end
      DS_COLLECT:
      begin
        if (RX_BYTE_VLD)
        begin
          s_nxt.rbuf[s_r.rcnt] = RX_BYTE;
          s_nxt.rcnt           = s_r.rcnt + 5'h01;
          s_nxt.need           = s_r.need - 5'h01;
          if (s_r.need == 5'h01)
          begin
            s_nxt.irq = 1'b1;
            s_nxt.err = !CRC_OK;
            if (s_r.task_id != TK_RX_BLOCK)
            begin
              s_nxt.match = HDR_MATCH;
            end
            s_nxt.st = DS_IDLE;
          end
        end
      end
      default:
      begin
        s_nxt.st = DS_IDLE;
      end
    endcase

    // a newly written task replaces whatever runs
    if (link.task_wr)
    begin
      s_nxt.task_id = link.task_code;
      s_nxt.bitc    = 3'h0;
      s_nxt.tptr    = 5'h00;
      case (link.task_code)
        TK_TX_HEADER:
        begin
          s_nxt.st   = DS_TAKE;
          s_nxt.need = TX_HDR_BYTES;
        end
        TK_TX_BLOCK:
        begin
          s_nxt.st   = DS_TAKE;
          s_nxt.need = TX_BLK_BYTES;
        end
        TK_TX_SINGLE:
        begin
          s_nxt.st   = DS_TAKE;
          s_nxt.need = TX_ONE_BYTE;
        end
        TK_LOAD_SYNC:
        begin
          s_nxt.st   = DS_TAKE;
          s_nxt.need = SYNC_BYTES;
        end
        TK_SEARCH_HEAD, TK_SEARCH_SHORT:
        begin
          s_nxt.st   = DS_HUNT;
          s_nxt.rcnt = 5'h00;
          s_nxt.rptr = 5'h00;
        end
        TK_RX_BLOCK:
        begin
          s_nxt.st   = DS_COLLECT;
          s_nxt.need = RX_BLK_BYTES;
          s_nxt.rcnt = 5'h00;
          s_nxt.rptr = 5'h00;
        end
        default:
        begin
          s_nxt.st = DS_IDLE;
        end
      endcase
    end

    // level acquisition sequence
    if (BIT_TICK && s_r.lph != LP_OFF && s_r.lcnt != 6'h3F)
    begin
      s_nxt.lcnt = s_r.lcnt + 6'h01;
    end
    case (s_r.lph)
      LP_CLAMP:
      begin
        if (BIT_TICK && s_r.lcnt + 6'h01 == CLAMP_BITS)
        begin
          s_nxt.lph = LP_LOSSY;
        end
      end
      LP_LOSSY:
      begin
        if (s_r.lsrch)
        begin
          if (sync_hit)
          begin
            s_nxt.lph = LP_RESID;
          end
        end
        else if (BIT_TICK && s_r.lcnt + 6'h01 == LEV_RESID_BITS)
        begin
          s_nxt.lph = LP_RESID;
        end
      end
      default:
      begin
      end
    endcase
    if (is_search && s_r.lph != LP_OFF && s_r.lcnt < LEV_SEARCH_WIN)
    begin
      s_nxt.lsrch = 1'b1;
    end

    // clock loop bandwidth sequence
    if (BIT_TICK && s_r.cph != CP_OFF && s_r.ccnt != 6'h3F)
    begin
      s_nxt.ccnt = s_r.ccnt + 6'h01;
    end
    case (s_r.cph)
      CP_WIDE:
      begin
        if (s_r.csrch ? sync_hit : (BIT_TICK && s_r.ccnt + 6'h01 == WIDE_BITS))
        begin
          s_nxt.cph  = CP_MED;
          s_nxt.ccnt = 6'h00;
        end
      end
      CP_MED:
      begin
        if (BIT_TICK && s_r.ccnt + 6'h01 == MEDIUM_BITS)
        begin
          s_nxt.cph = CP_RESID;
        end
      end
      default:
      begin
      end
    endcase
    if (is_search && s_r.cph == CP_WIDE && s_r.ccnt < CLK_SEARCH_WIN)
    begin
      s_nxt.csrch = 1'b1;
    end

    // acquire commands restart the sequences
    if (link.task_wr && link.level_acquire_cmd)
    begin
      s_nxt.lph   = LP_CLAMP;
      s_nxt.lcnt  = 6'h00;
      s_nxt.lsrch = is_search;
    end
    if (link.task_wr && link.clock_acquire_cmd)
    begin
      s_nxt.cph   = CP_WIDE;
      s_nxt.ccnt  = 6'h00;
      s_nxt.csrch = is_search;
    end
  end

  always_ff @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      s_r <= '0;
    end
    else
    begin
      s_r <= s_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs
  always_comb
  begin
    case (s_r.lph)
      LP_CLAMP:
      begin
        LEVEL_MODE = LV_CLAMP;
      end
      LP_LOSSY:
      begin
        LEVEL_MODE = LV_LOSSY;
      end
      LP_RESID:
      begin
        case (link.residual_level_mode)
          RES_PEAK: LEVEL_MODE = LV_PEAK;
          RES_AVG:  LEVEL_MODE = LV_AVG;
          RES_HOLD: LEVEL_MODE = LV_HOLD;
          default:  LEVEL_MODE = LV_LOSSY;
        endcase
      end
      default:
      begin
        LEVEL_MODE = LV_OFF;
      end
    endcase
  end

  // settle point of the lossy detector on a bit sync pattern
  assign LEVEL_SETTLED = s_r.lph != LP_OFF && s_r.lph != LP_CLAMP &&
                         s_r.lcnt >= CLAMP_BITS + LOSSY_SETTLE;
  assign CLOCK_PHASE   = s_r.cph;
  assign LOOP_BW       = (s_r.cph == CP_RESID) ? link.loop_bandwidth_sel : s_r.cph;
  assign TX_BYTE       = s_r.tx_byte;
  assign TX_BYTE_VLD   = s_r.tx_vld;
  assign SYNC_WORD     = s_r.sync;

  assign link.rd_data          = s_r.rbuf[s_r.rptr];
  assign link.host_interrupt_n = !s_r.irq;
  assign link.status = {3'h0, s_r.rptr >= s_r.rcnt, s_r.st != DS_IDLE,
                        s_r.err, s_r.match, s_r.irq};
endmodule

// ===== rtl/rasq_pkg.sv
// Purpose: shared constants and types of the rx acquisition task sequencer
// Assumes: timing counts are in recovered bit periods, one BIT_TICK pulse each
// Notes:   host register offsets are byte addresses of 32-bit words
package rasq_pkg;

  typedef enum logic [2:0] {
    TK_IDLE,
    TK_TX_HEADER,
    TK_TX_BLOCK,
    TK_TX_SINGLE,
    TK_LOAD_SYNC,
    TK_SEARCH_HEAD,
    TK_SEARCH_SHORT,
    TK_RX_BLOCK
  } rasq_task_type;

  typedef enum logic [2:0] {
    LV_OFF,
    LV_CLAMP,
    LV_LOSSY,
    LV_PEAK,
    LV_AVG,
    LV_HOLD
  } rasq_level_type;

  // residual level field encodings
  localparam logic [1:0] RES_LOSSY = 2'h0;
  localparam logic [1:0] RES_PEAK  = 2'h1;
  localparam logic [1:0] RES_AVG   = 2'h2;
  localparam logic [1:0] RES_HOLD  = 2'h3;

  // clock loop phase
  localparam logic [1:0] CP_OFF   = 2'h0;
  localparam logic [1:0] CP_WIDE  = 2'h1;
  localparam logic [1:0] CP_MED   = 2'h2;
  localparam logic [1:0] CP_RESID = 2'h3;

  // buffer and byte counts
  localparam int         BUF_DEPTH     = 18;
  localparam logic [4:0] BUF_DEPTH_C   = 5'h12;
  localparam logic [4:0] TX_HDR_BYTES  = 5'h06;
  localparam logic [4:0] TX_BLK_BYTES  = 5'h12;
  localparam logic [4:0] TX_ONE_BYTE   = 5'h01;
  localparam logic [4:0] SYNC_BYTES    = 5'h02;
  localparam logic [4:0] HDR_BYTES     = 5'h02;
  localparam logic [4:0] RX_BLK_BYTES  = 5'h12;
  localparam logic [2:0] BYTE_LAST_BIT = 3'h7;

  // acquisition timing in bit times
  localparam logic [5:0] CLAMP_BITS     = 6'h01;
  localparam logic [5:0] LOSSY_SETTLE   = 6'h10;
  localparam logic [5:0] LEV_SEARCH_WIN = 6'h1C;
  localparam logic [5:0] LEV_RESID_BITS = 6'h1E;
  localparam logic [5:0] CLK_SEARCH_WIN = 6'h0E;
  localparam logic [5:0] WIDE_BITS      = 6'h10;
  localparam logic [5:0] MEDIUM_BITS    = 6'h1E;

  // host side timing in bit times
  localparam logic [3:0] SEARCH_GAP_BITS  = 4'hC;
  localparam logic [1:0] CARRIER_GAP_BITS = 2'h2;

  // trailing byte and preamble lengths
  localparam logic [7:0] HANG_BYTE    = 8'h33;
  localparam logic [5:0] PREAMBLE_STD = 6'h18;
  localparam logic [5:0] PREAMBLE_LNG = 6'h30;

  // device status bits
  localparam int ST_IRQ   = 0;
  localparam int ST_MATCH = 1;
  localparam int ST_ERR   = 2;
  localparam int ST_BUSY  = 3;
  localparam int ST_EMPTY = 4;

  // host APB register offsets
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_DATA   = 8'h04;
  localparam logic [7:0] OFS_STATUS = 8'h08;
  localparam logic [7:0] OFS_HSTAT  = 8'h0C;

  // control register fields
  localparam int CT_TASK_LSB = 0;
  localparam int CT_LEV      = 3;
  localparam int CT_CLK      = 4;
  localparam int CT_RES_LSB  = 5;
  localparam int CT_BW_LSB   = 7;
  localparam int CT_BLIND    = 9;
  localparam int CT_HANG     = 10;

endpackage

// ===== rtl/rasq_link_if.sv
// Purpose: parallel task and data port between host end and device end
// Assumes: one clock shared by both ends
// Notes:   host_interrupt_n is active low
`timescale 1ns/1ps
interface rasq_link_if;
  import rasq_pkg::*;
  rasq_task_type task_code;
  logic          task_wr;
  logic          level_acquire_cmd;
  logic          clock_acquire_cmd;
  logic [1:0]    residual_level_mode;
  logic [1:0]    loop_bandwidth_sel;
  logic [7:0]    wr_data;
  logic          wr_strobe;
  logic          rd_strobe;
  logic [7:0]    rd_data;
  logic          stat_rd;
  logic [7:0]    status;
  logic          host_interrupt_n;

  modport dev (
    input  task_code, task_wr, level_acquire_cmd, clock_acquire_cmd,
    input  residual_level_mode, loop_bandwidth_sel, wr_data, wr_strobe,
    input  rd_strobe, stat_rd,
    output rd_data, status, host_interrupt_n
  );

  modport host (
    output task_code, task_wr, level_acquire_cmd, clock_acquire_cmd,
    output residual_level_mode, loop_bandwidth_sel, wr_data, wr_strobe,
    output rd_strobe, stat_rd,
    input  rd_data, status, host_interrupt_n
  );
endinterface

// ===== rtl/rasq_host.sv
// Purpose: host end: APB registers driving the task port of the device
// Assumes: pready is always high; reads see data latched in the setup cycle
// Notes:   timed tasks wait in a pending slot until their gap has passed
`timescale 1ns/1ps
module rasq_host (
  // clock and reset
  input  wire logic        CLK,
  input  wire logic        RST_N,
  // APB slave
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [7:0]  PADDR,
  input  wire logic [31:0] PWDATA,
  output      logic [31:0] PRDATA,
  output      logic        PREADY,
  output      logic        PSLVERR,
  // radio side
  input  wire logic        BIT_TICK,
  input  wire logic        CARRIER_DET,
  input  wire logic        FADE,
  output      logic        IRQ,
  output      logic [5:0]  PREAMBLE_LEN,
  // link to device
  rasq_link_if.host        link
);
  import rasq_pkg::*;

  typedef struct packed {
    logic          pend;
    rasq_task_type ptask;
    logic          plev;
    logic          pclk;
    logic [1:0]    res;
    logic [1:0]    bw;
    logic          blind;
    logic [3:0]    gap;
    logic [1:0]    car;
    logic          task_wr;
    logic          lev_out;
    logic          clk_out;
    logic [1:0]    res_out;
    logic          wr_stb;
    logic [7:0]    wdata;
    logic [31:0]   rdata;
  } rasq_host_state_type;

  rasq_host_state_type s_r;
  rasq_host_state_type s_nxt;
  logic                acc;
  logic                hit;
  logic                go;

  assign acc = PSEL && PENABLE;
  assign hit = PADDR == OFS_CTRL || PADDR == OFS_DATA ||
               PADDR == OFS_STATUS || PADDR == OFS_HSTAT;
  // search waits after a status read, load sync waits for carrier unless blind
  assign go  = s_r.pend &&
               (((s_r.ptask == TK_SEARCH_HEAD || s_r.ptask == TK_SEARCH_SHORT) &&
                 s_r.gap >= SEARCH_GAP_BITS) ||
                (s_r.ptask == TK_LOAD_SYNC && (s_r.blind || s_r.car >= CARRIER_GAP_BITS)) ||
                (s_r.ptask != TK_SEARCH_HEAD && s_r.ptask != TK_SEARCH_SHORT &&
                 s_r.ptask != TK_LOAD_SYNC));

  ////////////////////////////////////////////////////////////////////////////
  always_comb
  begin
    s_nxt         = s_r;
    s_nxt.task_wr = 1'b0;
    s_nxt.wr_stb  = 1'b0;
    if (BIT_TICK && s_r.gap < SEARCH_GAP_BITS)
    begin
      s_nxt.gap = s_r.gap + 4'h1;
    end
    if (!CARRIER_DET)
    begin
      s_nxt.car = 2'h0;
    end
    else if (BIT_TICK && s_r.car < CARRIER_GAP_BITS)
    begin
      s_nxt.car = s_r.car + 2'h1;
    end
    // hold is passed on only while a fade lasts
    s_nxt.res_out = (s_r.res == RES_HOLD && !FADE) ? RES_AVG : s_r.res;

    // setup cycle latches read data
    if (PSEL && !PENABLE && !PWRITE)
    begin
      case (PADDR)
        OFS_DATA:   s_nxt.rdata = {24'h0, link.rd_data};
        OFS_STATUS: s_nxt.rdata = {24'h0, link.status};
        OFS_HSTAT:  s_nxt.rdata = {30'h0, !link.host_interrupt_n, s_r.pend};
        OFS_CTRL:   s_nxt.rdata = {21'h0, 1'b0, s_r.blind, s_r.bw, s_r.res,
                                   s_r.pclk, s_r.plev, s_r.ptask};
        default:    s_nxt.rdata = 32'h0;
      endcase
    end
    if (acc && !PWRITE && PADDR == OFS_STATUS)
    begin
      s_nxt.gap = 4'h0;
    end

    if (go)
    begin
      s_nxt.pend    = 1'b0;
      s_nxt.task_wr = 1'b1;
      s_nxt.lev_out = s_r.plev;
      s_nxt.clk_out = s_r.pclk;
    end

    if (acc && PWRITE && PADDR == OFS_DATA)
    begin
      s_nxt.wr_stb = 1'b1;
      s_nxt.wdata  = PWDATA[7:0];
    end
    if (acc && PWRITE && PADDR == OFS_CTRL)
    begin
      s_nxt.pend  = 1'b1;
      s_nxt.ptask = rasq_task_type'(PWDATA[CT_TASK_LSB +: 3]);
      s_nxt.plev  = PWDATA[CT_LEV];
      s_nxt.pclk  = PWDATA[CT_CLK];
      s_nxt.res   = PWDATA[CT_RES_LSB +: 2];
      s_nxt.bw    = PWDATA[CT_BW_LSB +: 2];
      s_nxt.blind = PWDATA[CT_BLIND];
      // end of message: trailing byte loaded ahead of the single-byte task
      if (PWDATA[CT_HANG])
      begin
        s_nxt.ptask  = TK_TX_SINGLE;
        s_nxt.wr_stb = 1'b1;
        s_nxt.wdata  = HANG_BYTE;
      end
    end
  end

  always_ff @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      s_r     <= '0;
      s_r.gap <= SEARCH_GAP_BITS;
    end
    else
    begin
      s_r <= s_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  assign PRDATA  = s_r.rdata;
  assign PREADY  = 1'b1;
  assign PSLVERR = acc && !hit;
  assign IRQ     = !link.host_interrupt_n;
  // blind start needs a longer bit sync run from the far transmitter
  assign PREAMBLE_LEN = s_r.blind ? PREAMBLE_LNG : PREAMBLE_STD;

  // trailing byte is read like any byte and dropped by software
  assign link.rd_strobe          = acc && !PWRITE && PADDR == OFS_DATA;
  assign link.stat_rd            = acc && !PWRITE && PADDR == OFS_STATUS;
  assign link.task_code          = s_r.ptask;
  assign link.task_wr            = s_r.task_wr;
  assign link.level_acquire_cmd  = s_r.lev_out;
  assign link.clock_acquire_cmd  = s_r.clk_out;
  assign link.residual_level_mode = s_r.res_out;
  assign link.loop_bandwidth_sel = s_r.bw;
  assign link.wr_data            = s_r.wdata;
  assign link.wr_strobe          = s_r.wr_stb;
endmodule

// ===== test/rasq_chk.sv
// Purpose: assertions on the task port between host end and device end
// Assumes: one clock domain, reset active low
// Notes:   sees the link signals only
`timescale 1ns/1ps
module rasq_chk (
  // clock and reset
  input wire logic                    CLK,
  input wire logic                    RST_N,
  // link
  input wire rasq_pkg::rasq_task_type task_code,
  input wire logic                    task_wr,
  input wire logic                    wr_strobe,
  input wire logic                    rd_strobe,
  input wire logic                    stat_rd,
  input wire logic [7:0]              status,
  input wire logic                    host_interrupt_n
);
  import rasq_pkg::*;
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!RST_N);
  ////////////////////////////////////////
  sequence s_sync_load;
    task_wr && task_code == TK_LOAD_SYNC;
  endsequence
  sequence s_irq_rise;
    $fell(host_interrupt_n);
  endsequence
  property p_sync_irq;
    s_sync_load |-> ##[1:3] !host_interrupt_n;
  endproperty
  a_sync_irq: assert property (p_sync_irq)
    else $error("no interrupt after sync load");
  property p_irq_flag;
    status[ST_IRQ] == !host_interrupt_n;
  endproperty
  a_irq_flag: assert property (p_irq_flag)
    else $error("status irq bit differs from interrupt line");
  property p_stat_clr;
    stat_rd && !status[ST_BUSY] |=> host_interrupt_n;
  endproperty
  a_stat_clr: assert property (p_stat_clr)
    else $error("status read left interrupt set");
  property p_irq_busy;
    s_irq_rise |-> $past(status[ST_BUSY]);
  endproperty
  a_irq_busy: assert property (p_irq_busy)
    else $error("interrupt without a running task");
  property p_idle_after;
    s_irq_rise |-> ##[0:1] !status[ST_BUSY];
  endproperty
  a_idle_after: assert property (p_idle_after)
    else $error("device still busy after task end");
  property p_task_pulse;
    task_wr |=> !task_wr;
  endproperty
  a_task_pulse: assert property (p_task_pulse)
    else $error("task write longer than one cycle");
  property p_wr_pulse;
    wr_strobe |=> !wr_strobe;
  endproperty
  a_wr_pulse: assert property (p_wr_pulse)
    else $error("byte push longer than one cycle");
  property p_rd_pulse;
    rd_strobe |=> !rd_strobe;
  endproperty
  a_rd_pulse: assert property (p_rd_pulse)
    else $error("byte pop longer than one cycle");
endmodule

// ===== test/test_rx_acquisition_task_sequencer.sv
// Purpose: self-checking bench of host end and device end joined by the link
// Assumes: bit period of 8 clocks made by the bench
// Notes:   mode, phase and length expectations come from package constants; data values are literals
`timescale 1ns/1ps
module test_rx_acquisition_task_sequencer;
  import rasq_pkg::*;
  logic        clk, rst_n, psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr, rx_byte, tx_byte;
  logic [31:0] pwdata, prdata, rdat;
  logic        bit_tick, carrier_det, fade, irq, sync_found, hdr_match, crc_ok;
  logic        rx_byte_vld, tx_byte_vld, level_settled, rerr;
  logic [5:0]  preamble_len;
  logic [15:0] sync_word;
  logic [2:0]  level_mode, tcnt;
  logic [1:0]  clock_phase, loop_bw;
  logic [2:0]  res_exp [4];
  int          mismatches, total_checks, n;
  rasq_link_if link ();
  rasq_host i_rasq_host (.CLK(clk), .RST_N(rst_n), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
    .PSLVERR(pslverr), .BIT_TICK(bit_tick), .CARRIER_DET(carrier_det), .FADE(fade),
    .IRQ(irq), .PREAMBLE_LEN(preamble_len), .link(link));
  rasq_dev i_rasq_dev (.CLK(clk), .RST_N(rst_n), .link(link), .BIT_TICK(bit_tick),
    .SYNC_FOUND(sync_found), .HDR_MATCH(hdr_match), .CRC_OK(crc_ok), .RX_BYTE(rx_byte),
    .RX_BYTE_VLD(rx_byte_vld), .TX_BYTE(tx_byte), .TX_BYTE_VLD(tx_byte_vld),
    .SYNC_WORD(sync_word), .LEVEL_MODE(level_mode), .LEVEL_SETTLED(level_settled),
    .CLOCK_PHASE(clock_phase), .LOOP_BW(loop_bw));
  rasq_chk i_rasq_chk (.CLK(clk), .RST_N(rst_n), .task_code(link.task_code),
    .task_wr(link.task_wr), .wr_strobe(link.wr_strobe), .rd_strobe(link.rd_strobe),
    .stat_rd(link.stat_rd), .status(link.status), .host_interrupt_n(link.host_interrupt_n));
  ////////////////////////////////////////
  initial
  begin
    clk = 0;
    forever #4 clk = ~clk;
  end
  // one bit tick every 8 clocks
  always @(posedge clk)
  begin
    tcnt <= tcnt + 3'h1;
    bit_tick <= (tcnt == 3'h7);
  end
  ////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1;
    do @(posedge clk); while (pready !== 1'b1);
    rdat = prdata;
    rerr = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  task automatic ticks(input int k);
    repeat (k) @(posedge clk iff bit_tick);
    @(negedge clk);
  endtask
  task automatic wait_irq;
    n = 0;
    while (irq !== 1'b1 && n < 3000)
    begin
      @(posedge clk);
      n++;
    end
    ticks(0);
    chk(irq, 1);
  endtask
  // s high gives a frame sync pulse instead of a byte
  task automatic rxb(input logic [7:0] b, input logic s);
    @(posedge clk);
    rx_byte <= b;
    sync_found <= s;
    rx_byte_vld <= !s;
    @(posedge clk);
    sync_found <= 0;
    rx_byte_vld <= 0;
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  ////////////////////////////////////////
  // whole run needs about 3000 clocks
  initial
  begin
    repeat (20000) @(posedge clk);
    mismatches++;
    tally_and_finish;
  end
  initial
  begin
    {rst_n, psel, penable, pwrite, carrier_det, fade, sync_found, rx_byte_vld} = '0;
    {paddr, pwdata, rx_byte, tcnt, bit_tick, hdr_match, crc_ok} = '0;
    res_exp = '{LV_LOSSY, LV_PEAK, LV_AVG, LV_HOLD};
    repeat (12) @(posedge clk);
    rst_n <= 1;
    ticks(0);
    chk(level_mode, LV_OFF);
    chk(clock_phase, CP_OFF);
    chk(preamble_len, PREAMBLE_STD);
    apb(0, 8'h40, 32'h0);
    chk(rerr, 1);
    chk(rdat, 32'h0);
    $display("test reset done");
    // receive flow with search inside both windows
    apb(1, OFS_DATA, 32'h5A);
    hdr_match <= 1;
    crc_ok <= 1;
    apb(1, OFS_DATA, 32'hC3);
    carrier_det <= 1;
    apb(1, OFS_CTRL, 32'h138 | TK_LOAD_SYNC);
    wait_irq;
    chk(sync_word, 16'h5AC3);
    apb(0, OFS_HSTAT, 32'h0);
    chk(rdat, 32'h2);
    apb(0, OFS_STATUS, 32'h0);
    apb(1, OFS_CTRL, 32'h120 | TK_SEARCH_HEAD);
    ticks(40);
    chk(level_mode, LV_LOSSY);
    chk(clock_phase, CP_WIDE);
    chk(irq, 0);
    rxb(8'h00, 1);
    rxb(8'h81, 0);
    rxb(8'h7E, 0);
    wait_irq;
    chk(level_mode, LV_PEAK);
    chk(clock_phase, CP_MED);
    apb(0, OFS_STATUS, 32'h0);
    chk(rdat[ST_MATCH], 1);
    chk(rdat[ST_ERR], 0);
    apb(0, OFS_DATA, 32'h0);
    chk(rdat, 32'h81);
    apb(0, OFS_DATA, 32'h0);
    chk(rdat, 32'h7E);
    crc_ok <= 0;
    apb(1, OFS_CTRL, 32'h120 | TK_RX_BLOCK);
    repeat (4) @(posedge clk);
    for (int i = 0; i < 18; i++)
      rxb(8'h40 + 8'(i), 0);
    wait_irq;
    apb(0, OFS_STATUS, 32'h0);
    chk(rdat[ST_ERR], 1);
    chk(rdat[ST_EMPTY], 0);
    chk(rdat[ST_BUSY], 0);
    for (int i = 0; i < 18; i++)
    begin
      apb(0, OFS_DATA, 32'h0);
      chk(rdat, 32'h40 + i);
    end
    ticks(40);
    chk(clock_phase, CP_RESID);
    chk(loop_bw, 2'h2);
    $display("test receive done");
    // acquisition without search, every residual code
    for (int m = 0; m < 4; m++)
    begin
      ticks(1);
      apb(1, OFS_CTRL, 32'h18 | (m << 5) | (m << 7));
      fade <= (m == 3);
      repeat (4) @(posedge clk);
      ticks(0);
      chk(level_mode, LV_CLAMP);
      ticks(5);
      chk(level_mode, LV_LOSSY);
      chk(level_settled, 0);
      chk(clock_phase, CP_WIDE);
      ticks(15);
      chk(clock_phase, CP_MED);
      chk(level_mode, LV_LOSSY);
      chk(level_settled, 1);
      ticks(15);
      chk(level_mode, res_exp[m]);
      ticks(15);
      chk(loop_bw, m);
    end
    @(posedge clk) fade <= 0;
    ticks(1);
    chk(level_mode, LV_AVG);
    $display("test acquisition done");
    // frame head task drains six bytes, one per byte time
    for (int i = 0; i < 6; i++)
      apb(1, OFS_DATA, 32'h10 + i);
    apb(1, OFS_CTRL, 32'h0 | TK_TX_HEADER);
    wait_irq;
    chk(tx_byte, 32'h15);
    apb(0, OFS_STATUS, 32'h0);
    // end of message sends the hang byte
    apb(1, OFS_CTRL, 32'h400);
    n = 0;
    while (tx_byte_vld !== 1'b1 && n < 200)
    begin
      @(posedge clk);
      n++;
    end
    chk(tx_byte_vld, 1);
    chk(tx_byte, HANG_BYTE);
    wait_irq;
    apb(0, OFS_STATUS, 32'h0);
    apb(1, OFS_CTRL, 32'h200);
    ticks(0);
    chk(preamble_len, PREAMBLE_LNG);
    $display("test hang byte done");
    tally_and_finish;
  end
endmodule
